// file: rtl/snz_defines.svh
// Register offsets, field positions, reset values and timing counts of the snooze scan controller
`ifndef SNZ_DEFINES_SVH
`define SNZ_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SNZ_OFF_CTRL 8'h00
`define SNZ_OFF_TRIG 8'h04
`define SNZ_OFF_SELA 8'h08
`define SNZ_OFF_SELB 8'h0C
`define SNZ_OFF_PWR 8'h10
`define SNZ_OFF_STAT 8'h14
`define SNZ_OFF_RES 8'h40
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SNZ_CTRL_START 0
`define SNZ_CTRL_TRIGGER_ENABLE_BIT 1
`define SNZ_CTRL_EXTERNAL_TRIGGER_SELECT_BIT 2
`define SNZ_CTRL_SMODE 3
`define SNZ_CTRL_LOWPWR 5
`define SNZ_CTRL_COR 6
`define SNZ_TRIG_B 8
`define SNZ_PWR_SLEEP 0
`define SNZ_PWR_STBY 1
`define SNZ_PWR_TORUN 2
`define SNZ_PWR_SNZEN 3
`define SNZ_PWR_WAKE 4
`define SNZ_PWR_MODE 8
// ----------------------------------------
// Reset values and link source codes
// ----------------------------------------
`define SNZ_CTRL_RST 7'h00
`define SNZ_TRIG_RST 14'h3F3F
`define SNZ_PWR_RST 5'h1C
`define SNZ_TRS_LINK_A 6'h09
`define SNZ_TRS_LINK_B 6'h0A
// ----------------------------------------
// Timing
// ----------------------------------------
`define SNZ_CLK_NS 100
`define SNZ_CONV_HS_NS 1200
`define SNZ_CONV_LP_NS 4700
`define SNZ_CONV_HS_CYC ((`SNZ_CONV_HS_NS + `SNZ_CLK_NS - 1) / `SNZ_CLK_NS)
`define SNZ_CONV_LP_CYC ((`SNZ_CONV_LP_NS + `SNZ_CLK_NS - 1) / `SNZ_CLK_NS)
`endif

// file: rtl/snz_pkg.sv
// Types shared by the snooze scan controller
package snz_pkg;
	typedef enum logic [1:0] {
		SNZ_PM_RUN = 2'h0,
		SNZ_PM_STBY = 2'h1,
		SNZ_PM_SNOOZE = 2'h3,
		SNZ_PM_SLEEP = 2'h2
	} snz_pmode_t;
	typedef enum logic [1:0] {
		SNZ_SC_IDLE = 2'h0,
		SNZ_SC_CONV = 2'h1,
		SNZ_SC_STORE = 2'h3
	} snz_scan_t;
	typedef enum logic [1:0] {
		SNZ_SM_SINGLE = 2'h0,
		SNZ_SM_CONT = 2'h1,
		SNZ_SM_GROUP = 2'h2
	} snz_smode_t;
endpackage : snz_pkg

// file: rtl/snz_pwr.sv
// Power mode sequencer: run, light sleep, deep standby and snooze
`timescale 1ns/10ps
module snz_pwr #(
	parameter bit ALT_WAKE = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sleep_req,
	input wire logic stby_req,
	input wire logic snooze_to_run,
	input wire logic snooze_en,
	input wire logic [2:0] wake_en,
	input wire logic irq_any,
	input wire logic snooze_request_event,
	input wire logic transfer_done_event,
	input wire logic pin_interrupt_one,
	input wire logic pin_interrupt_two,
	input wire logic calendar_alarm_event,
	input wire logic data_op_flag_event,
	output snz_pkg::snz_pmode_t mode_q,
	output logic cpu_halt_q,
	output logic clk_stop_q,
	output logic snooze_active_q
);
	snz_pkg::snz_pmode_t mode_d;
	logic wake;
	assign wake = (wake_en[0] & pin_interrupt_one)
		| (wake_en[1] & (ALT_WAKE ? pin_interrupt_two : calendar_alarm_event))
		| (wake_en[2] & data_op_flag_event);
	// ----------------------------------------
	// Next mode
	// ----------------------------------------
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			snz_pkg::SNZ_PM_RUN: begin
				if (stby_req) begin
					mode_d = snz_pkg::SNZ_PM_STBY;
				end else if (sleep_req) begin
					mode_d = snz_pkg::SNZ_PM_SLEEP;
				end
			end
			snz_pkg::SNZ_PM_SLEEP: begin
				// Any interrupt, already routed by software, ends light sleep
				if (irq_any) begin
					mode_d = snz_pkg::SNZ_PM_RUN;
				end
			end
			snz_pkg::SNZ_PM_STBY: begin
				if (wake) begin
					mode_d = snz_pkg::SNZ_PM_RUN;
				end else if (snooze_en && snooze_request_event) begin
					mode_d = snz_pkg::SNZ_PM_SNOOZE;
				end
			end
			snz_pkg::SNZ_PM_SNOOZE: begin
				if (wake) begin
					mode_d = snz_pkg::SNZ_PM_RUN;
				end else if (transfer_done_event) begin
					mode_d = snz_pkg::SNZ_PM_STBY;
				end else if (irq_any) begin
					mode_d = snooze_to_run ? snz_pkg::SNZ_PM_RUN : snz_pkg::SNZ_PM_STBY;
				end
			end
			default: begin
				mode_d = snz_pkg::SNZ_PM_RUN;
			end
		endcase
	end
	// ----------------------------------------
	// Mode register and domain controls
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= snz_pkg::SNZ_PM_RUN;
			cpu_halt_q <= 1'b0;
			clk_stop_q <= 1'b0;
			snooze_active_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			cpu_halt_q <= mode_d != snz_pkg::SNZ_PM_RUN;
			clk_stop_q <= mode_d == snz_pkg::SNZ_PM_STBY;
			snooze_active_q <= mode_d == snz_pkg::SNZ_PM_SNOOZE;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_sleep_wake;
		@(posedge aclk) disable iff (!aresetn)
		mode_q == snz_pkg::SNZ_PM_SLEEP && irq_any |=> mode_q == snz_pkg::SNZ_PM_RUN && !cpu_halt_q;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("light sleep did not end on interrupt");
	property p_sleep_periph;
		@(posedge aclk) disable iff (!aresetn)
		mode_q == snz_pkg::SNZ_PM_SLEEP |-> cpu_halt_q && !clk_stop_q;
	endproperty
	a_sleep_periph: assert property (p_sleep_periph) else $error("light sleep stopped peripherals");
	property p_snooze_entry;
		@(posedge aclk) disable iff (!aresetn)
		$rose(snooze_active_q) |-> $past(mode_q) == snz_pkg::SNZ_PM_STBY && $past(snooze_request_event);
	endproperty
	a_snooze_entry: assert property (p_snooze_entry) else $error("snooze entered from wrong mode");
	property p_snooze_done;
		@(posedge aclk) disable iff (!aresetn)
		mode_q == snz_pkg::SNZ_PM_SNOOZE && transfer_done_event && !wake |=> clk_stop_q ##1 $stable(mode_q) || wake
			|| (mode_q == snz_pkg::SNZ_PM_SNOOZE);
	endproperty
	a_snooze_done: assert property (p_snooze_done) else $error("snooze did not return to standby");
	property p_wake_run;
		@(posedge aclk) disable iff (!aresetn)
		(mode_q == snz_pkg::SNZ_PM_STBY || mode_q == snz_pkg::SNZ_PM_SNOOZE) && wake
			|=> mode_q == snz_pkg::SNZ_PM_RUN;
	endproperty
	a_wake_run: assert property (p_wake_run) else $error("wake event did not reach run mode");
endmodule : snz_pwr

// file: rtl/snz_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module snz_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			q <= INIT;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Level moves only where stages two and three agree
			q <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
		end
	end
endmodule : snz_sync

// file: rtl/snz_top.sv
// Snooze power sequencing and converter scan control with AXI4-Lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "snz_defines.svh"
module snz_top #(
	parameter int NCH = 13,
	parameter bit ALT_WAKE = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic irq_any,
	input wire logic snooze_request_event,
	input wire logic timer1_underflow_event,
	input wire logic transfer_done_event,
	input wire logic pin_interrupt_one,
	input wire logic pin_interrupt_two,
	input wire logic calendar_alarm_event,
	input wire logic data_op_flag_event,
	input wire logic external_trigger_pin_n,
	input wire logic [11:0] conv_data,
	output logic [3:0] conv_ch,
	output logic conv_run,
	output logic scan_end_event,
	output logic link_to_converter,
	input wire logic xfer_rd,
	input wire logic [3:0] xfer_ch,
	output logic [15:0] xfer_data,
	output logic cpu_halt,
	output logic clk_stop,
	output logic snooze_active
);
	localparam logic [15:0] CH_MASK = 16'((32'h1 << NCH) - 32'h1);
	localparam logic [15:0] HS_CYC = 16'(`SNZ_CONV_HS_CYC);
	localparam logic [15:0] LP_CYC = 16'(`SNZ_CONV_LP_CYC);
	logic [6:0] ctrl_q;
	logic [13:0] trig_q;
	logic [15:0] sela_q;
	logic [15:0] selb_q;
	logic [6:0] pwr_q;
	logic [15:0] res_q [NCH];
	snz_pkg::snz_scan_t sst_q;
	snz_pkg::snz_pmode_t pmode;
	logic [4:0] ch_q;
	logic [15:0] cnt_q;
	logic grp_q;
	logic aw_q;
	logic w_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic ext_lvl;
	logic ext_prev_q;
	logic wr_go;
	logic rd_go;
	logic wr_ctrl;
	logic [31:0] wr_val;
	logic [31:0] rd_val;
	logic rd_hit;
	logic hw_set;
	logic hw_clr;
	logic [15:0] mask;
	logic [4:0] nxt;
	logic go_a;
	logic go_b;
	snz_pkg::snz_smode_t smode;
	function automatic logic [4:0] snz_first(input logic [15:0] m, input logic [4:0] from);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 15; i >= 0; i--) begin
			if (m[i] && 5'(i) >= from) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : snz_first
	// ----------------------------------------
	// Power sequencer and external pin
	// ----------------------------------------
	snz_pwr #(.ALT_WAKE(ALT_WAKE)) u_pwr (
		.aclk(aclk),
		.aresetn(aresetn),
		.sleep_req(wr_go && awaddr_q == `SNZ_OFF_PWR && wr_val[`SNZ_PWR_SLEEP]),
		.stby_req(wr_go && awaddr_q == `SNZ_OFF_PWR && wr_val[`SNZ_PWR_STBY]),
		.snooze_to_run(pwr_q[`SNZ_PWR_TORUN]),
		.snooze_en(pwr_q[`SNZ_PWR_SNZEN]),
		.wake_en(pwr_q[`SNZ_PWR_WAKE+:3]),
		.irq_any(irq_any),
		.snooze_request_event(snooze_request_event),
		.transfer_done_event(transfer_done_event),
		.pin_interrupt_one(pin_interrupt_one),
		.pin_interrupt_two(pin_interrupt_two),
		.calendar_alarm_event(calendar_alarm_event),
		.data_op_flag_event(data_op_flag_event),
		.mode_q(pmode),
		.cpu_halt_q(cpu_halt),
		.clk_stop_q(clk_stop),
		.snooze_active_q(snooze_active)
	);
	snz_sync #(.W(1), .INIT(1'b1)) u_ext (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(external_trigger_pin_n),
		.q(ext_lvl)
	);
	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign wr_go = aw_q && w_q && !bvalid;
	assign rd_go = arvalid && arready;
	assign wr_val = {wstrb_q[3] ? wdata_q[31:24] : 8'h00, wstrb_q[2] ? wdata_q[23:16] : 8'h00,
		wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};
	assign wr_ctrl = wr_go && awaddr_q == `SNZ_OFF_CTRL;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_q <= 1'b1;
				awready <= 1'b0;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_q <= 1'b1;
				wready <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
				bvalid <= 1'b1;
				bresp <= (awaddr_q <= `SNZ_OFF_PWR && awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (araddr)
			`SNZ_OFF_CTRL: rd_val = {25'h0, ctrl_q};
			`SNZ_OFF_TRIG: rd_val = {18'h0, trig_q};
			`SNZ_OFF_SELA: rd_val = {16'h0, sela_q};
			`SNZ_OFF_SELB: rd_val = {16'h0, selb_q};
			`SNZ_OFF_PWR: rd_val = {22'h0, pmode, 1'h0, pwr_q[6:2], 2'h0};
			`SNZ_OFF_STAT: rd_val = {26'h0, ch_q, sst_q != snz_pkg::SNZ_SC_IDLE};
			default: begin
				rd_hit = 1'b0;
				for (int i = 0; i < NCH; i++) begin
					if (araddr == `SNZ_OFF_RES + 8'(4 * i)) begin
						rd_hit = 1'b1;
						rd_val = {16'h0, res_q[i]};
					end
				end
			end
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end else if (rd_go) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_val;
			rresp <= rd_hit ? 2'h0 : 2'h2;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_q <= `SNZ_TRIG_RST;
			sela_q <= 16'h0000;
			selb_q <= 16'h0000;
			pwr_q <= {2'h0, `SNZ_PWR_RST};
		end else if (wr_go) begin
			// Software picks sources once trigger enable is set and external select cleared
			if (awaddr_q == `SNZ_OFF_TRIG) trig_q <= {wr_val[13:8], 2'h0, wr_val[5:0]} & `SNZ_TRIG_RST;
			if (awaddr_q == `SNZ_OFF_SELA) sela_q <= wr_val[15:0] & CH_MASK;
			if (awaddr_q == `SNZ_OFF_SELB) selb_q <= wr_val[15:0] & CH_MASK;
			if (awaddr_q == `SNZ_OFF_PWR) pwr_q <= {wr_val[6:2], 2'h0};
		end
	end
	// Hardware set wins over a software clear of the start bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `SNZ_CTRL_RST;
		end else begin
			if (hw_clr) ctrl_q[`SNZ_CTRL_START] <= 1'b0;
			if (wr_ctrl) ctrl_q <= wr_val[6:0];
			if (hw_set) ctrl_q[`SNZ_CTRL_START] <= 1'b1;
		end
	end
	// ----------------------------------------
	// Start sources
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_to_converter <= 1'b0;
			ext_prev_q <= 1'b1;
		end else begin
			link_to_converter <= (pmode == snz_pkg::SNZ_PM_STBY || pmode == snz_pkg::SNZ_PM_SNOOZE)
				? snooze_request_event : timer1_underflow_event;
			ext_prev_q <= ext_lvl;
		end
	end
	assign smode = snz_pkg::snz_smode_t'(ctrl_q[`SNZ_CTRL_SMODE+:2]);
	always_comb begin
		go_a = 1'b0;
		go_b = 1'b0;
		if (ctrl_q[`SNZ_CTRL_TRIGGER_ENABLE_BIT] && ctrl_q[`SNZ_CTRL_EXTERNAL_TRIGGER_SELECT_BIT]) begin
			go_a = ext_prev_q && !ext_lvl;
		end else if (ctrl_q[`SNZ_CTRL_TRIGGER_ENABLE_BIT]) begin
			go_a = link_to_converter && trig_q[5:0] == `SNZ_TRS_LINK_A;
			go_b = link_to_converter && trig_q[13:8] == `SNZ_TRS_LINK_B && smode == snz_pkg::SNZ_SM_GROUP;
		end else begin
			go_a = wr_ctrl && wr_val[`SNZ_CTRL_START];
		end
	end
	// ----------------------------------------
	// Scan engine
	// ----------------------------------------
	assign mask = grp_q ? selb_q : sela_q;
	assign nxt = snz_first(mask, ch_q + 5'h01);
	assign hw_set = sst_q == snz_pkg::SNZ_SC_IDLE && (go_a || go_b);
	assign hw_clr = sst_q == snz_pkg::SNZ_SC_STORE && nxt == 5'h10 && smode != snz_pkg::SNZ_SM_CONT;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sst_q <= snz_pkg::SNZ_SC_IDLE;
			ch_q <= 5'h00;
			cnt_q <= 16'h0000;
			grp_q <= 1'b0;
			conv_run <= 1'b0;
			scan_end_event <= 1'b0;
		end else begin
			scan_end_event <= 1'b0;
			case (sst_q)
				snz_pkg::SNZ_SC_IDLE: begin
					if (hw_set && snz_first(go_a ? sela_q : selb_q, 5'h00) != 5'h10) begin
						grp_q <= !go_a;
						ch_q <= snz_first(go_a ? sela_q : selb_q, 5'h00);
						cnt_q <= ctrl_q[`SNZ_CTRL_LOWPWR] ? LP_CYC : HS_CYC;
						conv_run <= 1'b1;
						sst_q <= snz_pkg::SNZ_SC_CONV;
					end
				end
				snz_pkg::SNZ_SC_CONV: begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001) begin
						conv_run <= 1'b0;
						sst_q <= snz_pkg::SNZ_SC_STORE;
					end
				end
				snz_pkg::SNZ_SC_STORE: begin
					cnt_q <= ctrl_q[`SNZ_CTRL_LOWPWR] ? LP_CYC : HS_CYC;
					if (nxt != 5'h10) begin
						ch_q <= nxt;
						conv_run <= 1'b1;
						sst_q <= snz_pkg::SNZ_SC_CONV;
					end else begin
						scan_end_event <= 1'b1;
						if (smode == snz_pkg::SNZ_SM_CONT && ctrl_q[`SNZ_CTRL_START] && !wr_ctrl) begin
							ch_q <= snz_first(mask, 5'h00);
							conv_run <= 1'b1;
							sst_q <= snz_pkg::SNZ_SC_CONV;
						end else begin
							sst_q <= snz_pkg::SNZ_SC_IDLE;
						end
					end
				end
				default: begin
					sst_q <= snz_pkg::SNZ_SC_IDLE;
				end
			endcase
		end
	end
	assign conv_ch = ch_q[3:0];
	// ----------------------------------------
	// Result registers and transfer read port
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NCH; i++) res_q[i] <= 16'h0000;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (sst_q == snz_pkg::SNZ_SC_STORE && ch_q == 5'(i)) begin
					res_q[i] <= {4'h0, conv_data};
				end else if (ctrl_q[`SNZ_CTRL_COR] && ((xfer_rd && xfer_ch == 4'(i))
					|| (rd_go && araddr == `SNZ_OFF_RES + 8'(4 * i)))) begin
					res_q[i] <= 16'h0000;
				end
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xfer_data <= 16'h0000;
		end else if (xfer_rd) begin
			xfer_data <= (32'(xfer_ch) < NCH) ? res_q[xfer_ch] : 16'h0000;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_single_stop;
		@(posedge aclk) disable iff (!aresetn)
		scan_end_event && smode == snz_pkg::SNZ_SM_SINGLE && !$past(wr_ctrl) |-> !ctrl_q[`SNZ_CTRL_START] ##1 !conv_run;
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single scan kept running");
	property p_cor_clear;
		@(posedge aclk) disable iff (!aresetn)
		xfer_rd && ctrl_q[`SNZ_CTRL_COR] && 32'(xfer_ch) < NCH && sst_q != snz_pkg::SNZ_SC_STORE
			|=> res_q[$past(xfer_ch)] == 16'h0000;
	endproperty
	a_cor_clear: assert property (p_cor_clear) else $error("result not cleared by read");
	property p_keep;
		@(posedge aclk) disable iff (!aresetn)
		xfer_rd && !ctrl_q[`SNZ_CTRL_COR] && sst_q != snz_pkg::SNZ_SC_STORE && 32'(xfer_ch) < NCH
			|=> xfer_data == res_q[$past(xfer_ch)];
	endproperty
	a_keep: assert property (p_keep) else $error("result lost on read");
	property p_route;
		@(posedge aclk) disable iff (!aresetn)
		pmode == snz_pkg::SNZ_PM_RUN |=> link_to_converter == $past(timer1_underflow_event);
	endproperty
	a_route: assert property (p_route) else $error("wrong event routed to converter");
	property p_ascend;
		@(posedge aclk) disable iff (!aresetn)
		sst_q == snz_pkg::SNZ_SC_STORE && nxt != 5'h10 |=> ch_q > $past(ch_q);
	endproperty
	a_ascend: assert property (p_ascend) else $error("channels out of order");
	c_cont: cover property (@(posedge aclk) disable iff (!aresetn)
		scan_end_event && smode == snz_pkg::SNZ_SM_CONT ##1 conv_run);
	c_group_b: cover property (@(posedge aclk) disable iff (!aresetn) go_b && sst_q == snz_pkg::SNZ_SC_IDLE);
	c_snooze_scan: cover property (@(posedge aclk) disable iff (!aresetn) snooze_active && scan_end_event);
endmodule : snz_top

// file: verif/snooze_adc_scan_control_test.sv
// Register, scan and power mode tests of the snooze scan controller
`timescale 1ns/10ps
`include "snz_defines.svh"
module snooze_adc_scan_control_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, xfer_rd, scan_end_event, link_to_converter;
	logic irq_any = 1'b0, snooze_request_event = 1'b0, pin_interrupt_one = 1'b0;
	logic timer1_underflow_event = 1'b0, data_op_flag_event = 1'b0, calendar_alarm_event = 1'b0, ext_trig_n = 1'b1;
	logic transfer_done_event, cpu_halt, clk_stop, conv_run, snooze_active;
	logic [11:0] conv_data = 12'h000;
	logic [3:0] conv_ch, xfer_ch;
	logic [15:0] xfer_data, got_a, got_b;
	int num_errors = 0, n_checks = 0, run_n = 0, base = 0;
	always #50 aclk = ~aclk;
	always @(posedge aclk) if (conv_run) run_n <= run_n + 1;
	always @(posedge aclk) conv_data <= {8'hA5, conv_ch};
	snz_top i_snz_top (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
		.bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .irq_any,
		.snooze_request_event, .timer1_underflow_event, .transfer_done_event, .pin_interrupt_one,
		.pin_interrupt_two(1'b0), .calendar_alarm_event, .data_op_flag_event,
		.external_trigger_pin_n(ext_trig_n), .conv_data, .conv_ch, .conv_run, .scan_end_event, .link_to_converter,
		.xfer_rd, .xfer_ch, .xfer_data, .cpu_halt, .clk_stop, .snooze_active
	);
	snz_xfer_model i_snz_xfer_model (
		.aclk, .aresetn, .scan_end_event, .xfer_data, .xfer_rd, .xfer_ch, .transfer_done_event, .got_a, .got_b
	);
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", 32'h0, {30'h0, bresp});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk($sformatf("rdata %h", a), e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd
	task automatic wait_end;
		int i;
		i = 0;
		while (scan_end_event !== 1'b1 && i < 400) begin
			@(posedge aclk);
			i++;
		end
		chk("scan end", 32'h1, {31'h0, scan_end_event});
		repeat (8) @(posedge aclk);
	endtask : wait_end
	task automatic pulse(input int k);
		@(posedge aclk);
		case (k)
			0: irq_any <= 1'b1;
			1: pin_interrupt_one <= 1'b1;
			2: timer1_underflow_event <= 1'b1;
			3: data_op_flag_event <= 1'b1;
			default: calendar_alarm_event <= 1'b1;
		endcase
		@(posedge aclk);
		{irq_any, pin_interrupt_one, timer1_underflow_event, data_op_flag_event, calendar_alarm_event} <= 5'h00;
		repeat (2) @(posedge aclk);
	endtask : pulse
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		$display("BAD watchdog expected finish seen timeout");
		conclude();
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h04, 32'h3F3F, 2'h0);
		rd(8'h10, 32'h1C, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		$display("test reset done");
		wr(8'h08, 32'h0E);
		wr(8'h00, 32'h01);
		wait_end();
		rd(8'h44, 32'hA51, 2'h0);
		rd(8'h44, 32'hA51, 2'h0);
		rd(8'h4C, 32'hA53, 2'h0);
		rd(8'h40, 32'h0, 2'h0);
		chk("xfer b", 32'hA53, {16'h0, got_b});
		$display("test single scan done");
		wr(8'h00, 32'h40);
		wr(8'h00, 32'h41);
		wait_end();
		chk("xfer a", 32'hA51, {16'h0, got_a});
		rd(8'h44, 32'h0, 2'h0);
		rd(8'h48, 32'hA52, 2'h0);
		rd(8'h48, 32'h0, 2'h0);
		$display("test clear on read done");
		wr(8'h04, 32'h3F09);
		wr(8'h00, 32'h02);
		wr(8'h10, 32'h1E);
		rd(8'h10, 32'h11C, 2'h0);
		chk("clk stop", 32'h1, {31'h0, clk_stop});
		@(posedge aclk);
		snooze_request_event <= 1'b1;
		@(posedge aclk);
		snooze_request_event <= 1'b0;
		#1 chk("link", 32'h1, {31'h0, link_to_converter});
		rd(8'h10, 32'h31C, 2'h0);
		chk("snooze", 32'h1, {31'h0, snooze_active});
		wait_end();
		rd(8'h10, 32'h11C, 2'h0);
		chk("snooze a", 32'hA51, {16'h0, got_a});
		chk("snooze b", 32'hA53, {16'h0, got_b});
		pulse(1);
		rd(8'h10, 32'h1C, 2'h0);
		chk("clk run", 32'h0, {31'h0, clk_stop});
		$display("test snooze done");
		wr(8'h10, 32'h1D);
		rd(8'h10, 32'h21C, 2'h0);
		chk("halt", 32'h1, {31'h0, cpu_halt});
		pulse(0);
		rd(8'h10, 32'h1C, 2'h0);
		$display("test sleep done");
		wr(8'h10, 32'h42);
		pulse(4);
		rd(8'h10, 32'h140, 2'h0);
		pulse(3);
		rd(8'h10, 32'h40, 2'h0);
		$display("test wake source done");
		wr(8'h0C, 32'h10);
		wr(8'h04, 32'h0A3F);
		wr(8'h00, 32'h12);
		base = run_n;
		pulse(2);
		wait_end();
		rd(8'h50, 32'hA54, 2'h0);
		rd(8'h14, 32'h08, 2'h0);
		chk("hs cycles", `SNZ_CONV_HS_CYC, run_n - base);
		$display("test group scan done");
		wr(8'h00, 32'h2E);
		base = run_n;
		ext_trig_n <= 1'b0;
		wait_end();
		chk("cont run", 32'h1, {31'h0, conv_run});
		wr(8'h00, 32'h2E);
		wait_end();
		chk("cont stop", 32'h0, {31'h0, conv_run});
		rd(8'h00, 32'h2E, 2'h0);
		chk("lp cycles", 6 * `SNZ_CONV_LP_CYC, run_n - base);
		ext_trig_n <= 1'b1;
		$display("test continuous done");
		conclude();
	end
endmodule : snooze_adc_scan_control_test

// file: verif/snz_xfer_model.sv
// Transfer controller model that unloads results after each scan end
`timescale 1ns/10ps
module snz_xfer_model #(
	parameter logic [3:0] CH_A = 4'h1,
	parameter logic [3:0] CH_B = 4'h3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scan_end_event,
	input wire logic [15:0] xfer_data,
	output logic xfer_rd,
	output logic [3:0] xfer_ch,
	output logic transfer_done_event,
	output logic [15:0] got_a,
	output logic [15:0] got_b
);
	logic [2:0] step_q;
	// ----------------------------------------
	// Chain: read A, read B, read B again, done
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_q <= 3'h0;
		end else if (step_q != 3'h0 || scan_end_event) begin
			step_q <= (step_q == 3'h4) ? 3'h0 : step_q + 3'h1;
		end
	end
	always_ff @(posedge aclk) begin
		if (step_q == 3'h2) begin
			got_a <= xfer_data;
		end
		if (step_q == 3'h4) begin
			got_b <= xfer_data;
		end
	end
	assign xfer_rd = step_q inside {3'h1, 3'h2, 3'h3};
	// Idle channel lines show a value no read uses
	assign xfer_ch = (step_q == 3'h1) ? CH_A : (step_q == 3'h0) ? ~CH_B : CH_B;
	assign transfer_done_event = step_q == 3'h4;
endmodule : snz_xfer_model
